// [shared/rbs_regs.vh]
`ifndef RBS_REGS_VH
`define RBS_REGS_VH

// Register offsets on the serial bus (8-bit register address).
`define RBS_ADDR_SUPPLY_MASK 8'h60
`define RBS_ADDR_READ_SELECT 8'h64
`define RBS_ADDR_BURST_SEL 8'h65
`define RBS_ADDR_SUPPLY_STATUS 8'h5B

// Addresses of the registers held outside this block; all but the comparator are burst-selectable.
`define RBS_ADDR_COMPARATOR 8'h40
`define RBS_ADDR_ALERT_STATUS 8'h41
`define RBS_ADDR_LIVE_FLAGS 8'h42
`define RBS_ADDR_RESULT_ONE 8'h43
`define RBS_ADDR_RESULT_TWO 8'h44
`define RBS_ADDR_DIAG_0 8'h45
`define RBS_ADDR_DIAG_1 8'h46
`define RBS_ADDR_DIAG_2 8'h47
`define RBS_ADDR_DIAG_3 8'h48
`define RBS_ADDR_INPUT_COUNTER 8'h49

// Reset values.
`define RBS_RST_SUPPLY_MASK 7'h00
`define RBS_RST_READ_SELECT 10'h000
`define RBS_RST_BURST_SEL 10'h3FF
`define RBS_RST_SUPPLY_STATUS 7'h00

// Field positions of the readback selector.
`define RBS_SEL_AUTO_BIT 9
`define RBS_SEL_HDR_BIT 8
`define RBS_SEL_PTR_MSB 7
`define RBS_SEL_PTR_LSB 0

// Widths of the implemented fields.
`define RBS_MASK_W 7
`define RBS_BSEL_W 10

// Serial frame layout: 32 bits, address byte then 16 data bits then 8 spare bits.
`define RBS_FRAME_BITS 6'd32
`define RBS_BURST_WRAP 6'd47
`define RBS_FRM_ADDR_MSB 31
`define RBS_FRM_ADDR_LSB 24
`define RBS_FRM_DATA_MSB 23
`define RBS_FRM_DATA_LSB 8

`endif

// [verilog/rbs_burst_next.v]
`include "rbs_regs.vh"

// Finds the next register address of a burst read, skipping deselected ones.
module rbs_burst_next (
    // Address of the register just returned.
    input wire [7:0] cur_addr,
    // Inclusion bits, one per selectable register.
    input wire [9:0] incl_sel,
    // Address of the next register to return.
    output reg [7:0] next_addr
);

    // Maps an address to its inclusion bit index; 15 means not selectable.
    function [3:0] sel_index;
        input [7:0] a;
        begin
            case (a)
                `RBS_ADDR_ALERT_STATUS: sel_index = 4'h0;
                `RBS_ADDR_LIVE_FLAGS: sel_index = 4'h1;
                `RBS_ADDR_RESULT_ONE: sel_index = 4'h2;
                `RBS_ADDR_RESULT_TWO: sel_index = 4'h3;
                `RBS_ADDR_DIAG_0: sel_index = 4'h4;
                `RBS_ADDR_DIAG_1: sel_index = 4'h5;
                `RBS_ADDR_DIAG_2: sel_index = 4'h6;
                `RBS_ADDR_DIAG_3: sel_index = 4'h7;
                `RBS_ADDR_INPUT_COUNTER: sel_index = 4'h8;
                `RBS_ADDR_SUPPLY_STATUS: sel_index = 4'h9;
                default: sel_index = 4'hF;
            endcase
        end
    endfunction

    // True when the address is selectable and its inclusion bit is clear.
    function skipped;
        input [7:0] a;
        input [9:0] s;
        reg [3:0] idx;
        begin
            idx = sel_index(a);
            if (idx == 4'hF) begin
                skipped = 1'b0;
            end else begin
                skipped = ~s[idx];
            end
        end
    endfunction

    integer i;

    // Step forward once, then past every deselected register in a row.
    always @* begin
        next_addr = cur_addr + 8'h01;
        for (i = 0; i < 11; i = i + 1) begin
            if (skipped(next_addr, incl_sel)) begin
                next_addr = next_addr + 8'h01;
            end
        end
    end

endmodule // rbs_burst_next

// [verilog/rbs_readback_alert.v]
`include "rbs_regs.vh"

module rbs_readback_alert (
    // Clock, reset and clock enable.
    input wire clk,
    input wire sys_rst,
    input wire ce,
    // Serial bus pins from the host.
    input wire sclk,
    input wire cs_n,
    input wire sdi,
    // Serial data out pin with its enable.
    output reg sdo,
    output reg sdo_oe,
    // Supply monitor fault levels, bit order as the status register.
    input wire [6:0] supply_fault,
    // Alert from the main alert logic, same clock.
    input wire main_alert,
    // Conversion ready flag, same clock.
    input wire conv_ready,
    // Digital input levels from the pins.
    input wire [3:0] din_level,
    // Alert output pin, active low open drain.
    output wire alert_n_oe,
    // Read port into the rest of the register file.
    output wire [7:0] ext_rd_addr,
    input wire [15:0] ext_rd_data,
    // Write port into the rest of the register file.
    output reg ext_wr_en,
    output reg [7:0] ext_wr_addr,
    output reg [15:0] ext_wr_data
);

    // Synchroniser stages for the bus pins; stage one feeds only stage two.
    reg sclk_s1;
    reg sclk_s2;
    reg sclk_d;
    reg cs_s1;
    reg cs_s2;
    reg cs_d;
    reg sdi_s1;
    reg sdi_s2;
    // Synchroniser stages for the fault and digital input pins.
    reg [6:0] fault_s1;
    reg [6:0] fault_s2;
    reg [3:0] din_s1;
    reg [3:0] din_s2;

    // Supply fault mask, one bit per status bit.
    reg [6:0] supply_fault_alert_mask;
    // Readback selector: auto enable, header select, pointer.
    reg auto_rd_en;
    reg frame_header_select;
    reg [7:0] rb_ptr;
    // Burst inclusion bits.
    reg [9:0] burst_inclusion_select;
    // Sticky supply fault status.
    reg [6:0] supply_status;

    // Frame state.
    reg frame_on;
    reg frame_rd;
    reg rd_pending;
    reg [5:0] bit_cnt;
    reg [31:0] in_sh;
    reg [31:0] out_sh;
    reg [7:0] burst_addr;

    // Edge decode of the synchronised pins.
    wire sclk_rise = sclk_s2 & ~sclk_d;
    wire sclk_fall = ~sclk_s2 & sclk_d;
    wire cs_fall = ~cs_s2 & cs_d;
    wire cs_rise = cs_s2 & ~cs_d;

    // Whole received frame, including the bit arriving on this edge.
    wire [31:0] in_word = {in_sh[30:0], sdi_s2};
    wire [7:0] wr_addr = in_word[`RBS_FRM_ADDR_MSB:`RBS_FRM_ADDR_LSB];
    wire [15:0] wr_data = in_word[`RBS_FRM_DATA_MSB:`RBS_FRM_DATA_LSB];
    // A frame completes when the thirty-second bit is taken.
    wire frame_done = frame_on & sclk_rise & (bit_cnt == `RBS_FRAME_BITS - 6'd1);
    // Burst words follow once the first frame has gone out.
    wire burst_phase = frame_on & (bit_cnt >= `RBS_FRAME_BITS);

    // Next register of a burst after the one just returned.
    wire [7:0] nxt_addr;

    rbs_burst_next u_burst_next (
        .cur_addr(burst_addr),
        .incl_sel(burst_inclusion_select),
        .next_addr(nxt_addr)
    );

    // One read path: the pointer for the first word, the burst step after it.
    wire [7:0] rd_addr = burst_phase ? nxt_addr : rb_ptr;
    assign ext_rd_addr = rd_addr;

    // Returns the 16-bit read value of a register of this block or outside.
    function [15:0] reg_read;
        input [7:0] a;
        input [15:0] ext;
        begin
            case (a)
                `RBS_ADDR_SUPPLY_MASK: reg_read = {9'h000, supply_fault_alert_mask};
                `RBS_ADDR_READ_SELECT: reg_read = {6'h00, auto_rd_en, frame_header_select, rb_ptr};
                `RBS_ADDR_BURST_SEL: reg_read = {6'h00, burst_inclusion_select};
                `RBS_ADDR_SUPPLY_STATUS: reg_read = {9'h000, supply_status};
                default: reg_read = ext;
            endcase
        end
    endfunction

    wire [15:0] rd_word = reg_read(rd_addr, ext_rd_data);

    // Alert pin is pulled low while an unmasked sticky status bit or the main alert stands.
    wire supply_alert = |(supply_status & ~supply_fault_alert_mask);
    assign alert_n_oe = supply_alert | main_alert;

    // Header bits 30..24 of a read frame.
    wire [6:0] hdr_bits = frame_header_select ? {1'b0, conv_ready, alert_n_oe, din_s2}
        : rb_ptr[6:0];

    // Frame loaded into the output shifter when a read frame opens.
    wire [31:0] rd_frame = {1'b0, hdr_bits, rd_word, 8'h00};

    // Two-flop synchronisers for every pin input.
    always @(posedge clk) begin
        if (sys_rst) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_d <= 1'b0;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_d <= 1'b1;
            sdi_s1 <= 1'b0;
            sdi_s2 <= 1'b0;
            fault_s1 <= 7'h00;
            fault_s2 <= 7'h00;
            din_s1 <= 4'h0;
            din_s2 <= 4'h0;
        end else if (ce) begin
            sclk_s1 <= sclk;
            sclk_s2 <= sclk_s1;
            sclk_d <= sclk_s2;
            cs_s1 <= cs_n;
            cs_s2 <= cs_s1;
            cs_d <= cs_s2;
            sdi_s1 <= sdi;
            sdi_s2 <= sdi_s1;
            fault_s1 <= supply_fault;
            fault_s2 <= fault_s1;
            din_s1 <= din_level;
            din_s2 <= din_s1;
        end
    end

    // Frame tracking, bit counting and input shifting.
    always @(posedge clk) begin
        if (sys_rst) begin
            frame_on <= 1'b0;
            bit_cnt <= 6'd0;
            in_sh <= 32'h0000_0000;
        end else if (ce) begin
            if (cs_rise) begin
                // Host ended the frame; a short frame is discarded.
                frame_on <= 1'b0;
            end else if (cs_fall) begin
                // New frame opens with an empty shifter.
                frame_on <= 1'b1;
                bit_cnt <= 6'd0;
                in_sh <= 32'h0000_0000;
            end else if (frame_on & sclk_rise) begin
                in_sh <= in_word;
                if (bit_cnt == `RBS_BURST_WRAP) begin
                    // Each further 16-bit burst word restarts the word count.
                    bit_cnt <= `RBS_FRAME_BITS;
                end else begin
                    bit_cnt <= bit_cnt + 6'd1;
                end
            end
        end
    end

    // Output shifter: loaded at frame open and at each burst word.
    always @(posedge clk) begin
        if (sys_rst) begin
            frame_rd <= 1'b0;
            rd_pending <= 1'b0;
            out_sh <= 32'h0000_0000;
            burst_addr <= 8'h00;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end else if (ce) begin
            if (cs_fall) begin
                // Data goes out when auto readback is on or a read was armed.
                frame_rd <= auto_rd_en | rd_pending;
                rd_pending <= 1'b0;
                // The start register is returned whatever its select bit.
                burst_addr <= rb_ptr;
                if (auto_rd_en | rd_pending) begin
                    out_sh <= rd_frame;
                    sdo <= rd_frame[31];
                end else begin
                    out_sh <= 32'h0000_0000;
                    sdo <= 1'b0;
                end
                sdo_oe <= 1'b1;
            end else if (cs_rise) begin
                sdo_oe <= 1'b0;
                sdo <= 1'b0;
            end else if (frame_on & sclk_fall) begin
                if (burst_phase & (bit_cnt == `RBS_FRAME_BITS) & frame_rd) begin
                    // Next included register goes out as a 16-bit word.
                    out_sh <= {rd_word, 16'h0000};
                    sdo <= rd_word[15];
                    burst_addr <= nxt_addr;
                end else begin
                    out_sh <= {out_sh[30:0], 1'b0};
                    sdo <= out_sh[30];
                end
            end
            // A write to the selector arms an explicit read for the next frame.
            if (frame_done & (wr_addr == `RBS_ADDR_READ_SELECT)) begin
                rd_pending <= 1'b1;
            end
        end
    end

    // Register writes of a completed frame; reserved bits are dropped.
    always @(posedge clk) begin
        if (sys_rst) begin
            supply_fault_alert_mask <= `RBS_RST_SUPPLY_MASK;
            {auto_rd_en, frame_header_select, rb_ptr} <= `RBS_RST_READ_SELECT;
            burst_inclusion_select <= `RBS_RST_BURST_SEL;
            ext_wr_en <= 1'b0;
            ext_wr_addr <= 8'h00;
            ext_wr_data <= 16'h0000;
        end else if (ce) begin
            ext_wr_en <= 1'b0;
            if (frame_done) begin
                case (wr_addr)
                    `RBS_ADDR_SUPPLY_MASK: begin
                        // Seven mask bits line up with the status bits.
                        supply_fault_alert_mask <= wr_data[`RBS_MASK_W-1:0];
                    end
                    `RBS_ADDR_READ_SELECT: begin
                        auto_rd_en <= wr_data[`RBS_SEL_AUTO_BIT];
                        frame_header_select <= wr_data[`RBS_SEL_HDR_BIT];
                        rb_ptr <= wr_data[`RBS_SEL_PTR_MSB:`RBS_SEL_PTR_LSB];
                    end
                    `RBS_ADDR_BURST_SEL: begin
                        burst_inclusion_select <= wr_data[`RBS_BSEL_W-1:0];
                    end
                    `RBS_ADDR_SUPPLY_STATUS: begin
                        // Handled by the status process below.
                        ext_wr_en <= 1'b0;
                    end
                    default: begin
                        // Other addresses go to the rest of the register file.
                        ext_wr_en <= 1'b1;
                        ext_wr_addr <= wr_addr;
                        ext_wr_data <= wr_data;
                    end
                endcase
            end
        end
    end

    // Sticky status: a live fault sets its bit even when masked, and wins
    // over a write-one clear in the same cycle.
    wire [6:0] status_clr = (frame_done & (wr_addr == `RBS_ADDR_SUPPLY_STATUS)) ?
        wr_data[6:0] : 7'h00;
    wire [6:0] next_supply_status = (supply_status & ~status_clr) | fault_s2;

    always @(posedge clk) begin
        if (sys_rst) begin
            supply_status <= `RBS_RST_SUPPLY_STATUS;
        end else if (ce) begin
            supply_status <= next_supply_status;
        end
    end

endmodule // rbs_readback_alert

// [verification/rbs_readback_alert_monitor.sv]
module rbs_readback_alert_monitor (
    // Clock and reset.
    input logic clk,
    input logic sys_rst,
    // Serial pins.
    input logic cs_n,
    input logic sdo_oe,
    // Alert source and alert pin enable.
    input logic main_alert,
    input logic alert_n_oe,
    // Register file write port.
    input logic ext_wr_en,
    input logic [7:0] ext_wr_addr,
    input logic [15:0] ext_wr_data
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // The driver turns on within four clocks of a frame opening.
    a_oe_opens: assert property ($fell(cs_n) |-> ##[1:4] sdo_oe)
        else $error("sdo enable late after frame start");
    // The driver stays on while chip select is held low.
    a_oe_holds: assert property (sdo_oe && !cs_n |=> sdo_oe)
        else $error("sdo enable dropped inside a frame");
    // The driver is off once chip select has been high for five clocks.
    a_oe_idle: assert property (cs_n && $past(cs_n, 5) |-> !sdo_oe)
        else $error("sdo driven outside a frame");
    // A write strobe lasts exactly one clock.
    a_wr_single: assert property (ext_wr_en |=> !ext_wr_en)
        else $error("write strobe longer than one clock");
    // Address and data of the write port move only with the strobe.
    a_wr_hold: assert property (!ext_wr_en |-> $stable(ext_wr_addr) && $stable(ext_wr_data))
        else $error("write port changed without strobe");
    // The main alert always reaches the pin.
    a_alert_main: assert property (main_alert |-> alert_n_oe)
        else $error("alert pin idle while main alert set");
    // Without a frame nothing can clear a pending supply alert.
    a_alert_sticky: assert property ($past(alert_n_oe) && !$past(main_alert) && cs_n && $past(cs_n, 8) |-> alert_n_oe)
        else $error("alert dropped with no clearing write");
    // Leaving reset, the serial driver and write strobe are quiet.
    a_reset_quiet: assert property ($past(sys_rst) |-> !sdo_oe && !ext_wr_en)
        else $error("outputs active straight after reset");

    // Main scenarios reached.
    c_write: cover property (ext_wr_en);
    c_alert_cleared: cover property ($fell(alert_n_oe) && !main_alert);
    c_frame: cover property ($rose(sdo_oe) ##[8:400] $fell(sdo_oe));
endmodule // rbs_readback_alert_monitor

// [verification/rbs_spi_host.sv]
module rbs_spi_host (
    // System clock, only to align frame starts.
    input logic clk,
    // Serial pins toward the device.
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input logic sdo
);
    timeunit 1ns;
    timeprecision 1ns;
    // Last frame word and burst words taken from sdo.
    logic [31:0] rx_word;
    logic [15:0] rx_burst [0:7];

    // Idle pins: clock parked low, chip select high.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    // Sends the top nb bits of w and then extra burst words, taking sdo at each rising clock.
    task automatic xfer(input logic [31:0] w, input int nb, input int extra);
        int i;
        @(posedge clk);
        #1 cs_n = 1'b0;
        #400;
        for (i = 0; i < nb + 16 * extra; i++) begin
            sdi = (i < 32) ? w[31 - i] : 1'b0;
            #160 sclk = 1'b1;
            if (i < 32) rx_word[31 - i] = sdo;
            else rx_burst[(i - 32) / 16][15 - (i - 32) % 16] = sdo;
            #160 sclk = 1'b0;
        end
        #160 cs_n = 1'b1;
        // Data line is released; flip it so no stale bit lingers.
        sdi = ~sdi;
        #400;
    endtask
endmodule // rbs_spi_host

// [verification/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // Clock, reset and stimulus inputs.
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic main_alert = 1'b0;
    // Clock enable, held high except in the freeze test.
    logic ce = 1'b1;
    logic conv_ready = 1'b0;
    logic [6:0] supply_fault = 7'h00;
    logic [3:0] din_level = 4'h0;
    // Serial pins and design outputs.
    logic sclk, cs_n, sdi, sdo, sdo_oe, alert_n_oe, ext_wr_en;
    logic [7:0] ext_rd_addr, ext_wr_addr;
    logic [15:0] ext_wr_data;
    // Rest of the register file: a tag byte over the address.
    wire logic [15:0] ext_rd_data = {8'hA5, ext_rd_addr};
    int n_errors = 0;
    int cmp_count = 0;
    // Rows: write address, write data, readback pointer, expected data.
    logic [47:0] rows [0:7] = '{48'h00_1234_60_0000, 48'h00_0000_65_03FF, 48'h00_0000_5B_0000,
        48'h00_0000_64_0064, 48'h60_FFFF_60_007F, 48'h65_FFFF_65_03FF, 48'h65_0000_65_0000,
        48'h00_BEEF_43_A543};
    // Burst inclusion pattern: only bits 1 and 4 to 7 set.
    localparam logic [9:0] sel_pat = 10'h0F2;
    logic [7:0] a, p;
    logic [15:0] d, e;
    logic [6:0] m;

    rbs_readback_alert uut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe), .supply_fault(supply_fault), .main_alert(main_alert),
        .conv_ready(conv_ready), .din_level(din_level), .alert_n_oe(alert_n_oe), .ext_rd_addr(ext_rd_addr),
        .ext_rd_data(ext_rd_data), .ext_wr_en(ext_wr_en), .ext_wr_addr(ext_wr_addr), .ext_wr_data(ext_wr_data));
    rbs_spi_host host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

    // Compares one value and counts it.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One whole write frame.
    task automatic wr(input logic [7:0] adr, input logic [15:0] dat);
        host.xfer({adr, dat, 8'h00}, 32, 0);
    endtask

    // Points the readback at ptr, then reads it with extra burst words.
    task automatic rd(input logic [7:0] ptr, input int extra);
        wr(8'h64, {8'h00, ptr});
        host.xfer(32'h0, 32, extra);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // 25 MHz clock.
    initial forever #20 clk = ~clk;

    // Watchdog well beyond the expected run of about one millisecond.
    initial begin
        #3_000_000;
        n_errors++;
        stop_test();
    end

    // Main sequence.
    initial begin
        repeat (8) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (3) @(posedge clk);
        foreach (rows[k]) begin
            {a, d, p, e} = rows[k];
            wr(a, d);
            chk("non-read frame", 32'h0, host.rx_word);
            if (a == 8'h00) chk("ext write", {8'h00, a, d}, {8'h00, ext_wr_addr, ext_wr_data});
            rd(p, 0);
            chk("readback", {1'b0, p[6:0], e, 8'h00}, host.rx_word);
        end
        $display("test register rows done");
        host.xfer(32'h6000_0000, 24, 0);
        rd(8'h60, 0);
        chk("mask after short frame", 16'h007F, host.rx_word[23:8]);
        $display("test short frame done");
        @(posedge clk) #1 conv_ready = 1'b1;
        din_level = 4'hA;
        wr(8'h64, 16'h0343);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) #1 main_alert = k[0];
            host.xfer(32'h0, 32, 0);
            chk("auto readback", {2'b00, 1'b1, k[0], 4'hA, 16'hA543, 8'h00}, host.rx_word);
        end
        @(posedge clk) #1 main_alert = 1'b0;
        $display("test auto readback done");
        wr(8'h64, 16'h025B);
        for (int n = 0; n < 7; n++) begin
            m = 7'h01 << n;
            wr(8'h60, {9'h000, ~m});
            @(posedge clk) #1 supply_fault = m;
            repeat (8) @(posedge clk);
            chk("alert, other bits masked", 1, alert_n_oe);
            wr(8'h60, {9'h000, m});
            chk("alert masked", 0, alert_n_oe);
            @(posedge clk) #1 supply_fault = 7'h00;
            wr(8'h60, 16'h0000);
            chk("masked fault status", {9'h000, m}, host.rx_word[23:8]);
            chk("alert after fault gone", 1, alert_n_oe);
            wr(8'h5B, {9'h000, m});
            chk("alert after clear", 0, alert_n_oe);
        end
        $display("test supply alerts done");
        // A clear while the fault still stands loses to the set.
        @(posedge clk) #1 supply_fault = 7'h01;
        repeat (8) @(posedge clk);
        wr(8'h5B, 16'h0001);
        chk("alert after clear with fault", 1, alert_n_oe);
        @(posedge clk) #1 supply_fault = 7'h00;
        repeat (8) @(posedge clk);
        wr(8'h5B, 16'h0001);
        chk("alert after clear without fault", 0, alert_n_oe);
        // Clock enable low freezes the synchronisers and the status.
        @(posedge clk) #1 ce = 1'b0;
        supply_fault = 7'h02;
        repeat (8) @(posedge clk);
        chk("alert with clock enable low", 0, alert_n_oe);
        @(posedge clk) #1 ce = 1'b1;
        repeat (8) @(posedge clk);
        chk("alert with clock enable high", 1, alert_n_oe);
        @(posedge clk) #1 supply_fault = 7'h00;
        repeat (8) @(posedge clk);
        wr(8'h5B, 16'h0002);
        chk("alert after enable test", 0, alert_n_oe);
        $display("test clear and clock enable done");
        wr(8'h65, {6'h00, sel_pat});
        for (int s = 8'h40; s < 8'h42; s++) begin
            rd(s[7:0], 6);
            a = s[7:0];
            chk("burst start", {8'hA5, a}, host.rx_word[23:8]);
            for (int k = 0; k < 6; k++) begin
                a++;
                while (a > 8'h40 && a < 8'h4A && !sel_pat[a - 8'h41]) a++;
                chk("burst word", {8'hA5, a}, host.rx_burst[k]);
            end
        end
        $display("test burst done");
        @(posedge clk) #1 sys_rst = 1'b1;
        repeat (3) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (3) @(posedge clk);
        rd(8'h65, 0);
        chk("burst select after reset", 16'h03FF, host.rx_word[23:8]);
        $display("test mid-run reset done");
        stop_test();
    end
endmodule // tb

bind rbs_readback_alert rbs_readback_alert_monitor mon (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n),
    .sdo_oe(sdo_oe), .main_alert(main_alert), .alert_n_oe(alert_n_oe), .ext_wr_en(ext_wr_en),
    .ext_wr_addr(ext_wr_addr), .ext_wr_data(ext_wr_data));
